//--- rtl/block_memory_regs.svh
// register offsets, field positions, reset values and sizes of the two-port block memory
`ifndef BLOCK_MEMORY_REGS_SVH
`define BLOCK_MEMORY_REGS_SVH

`define MEM_DEPTH 256
`define MEM_ADDR_BITS 8
`define MEM_DATA_BITS 16
`define GLOBAL_BUFFERS 8

`define BUS_ADDR_BITS 5
`define CONTROL_OFFSET 5'h00
`define PRELOAD_ADDR_OFFSET 5'h04
`define PRELOAD_DATA_OFFSET 5'h08
`define STATUS_OFFSET 5'h0c
`define WRITE_COUNT_OFFSET 5'h10
`define READ_COUNT_OFFSET 5'h14

`define CTRL_WRITE_FALLING_BIT 0
`define CTRL_READ_FALLING_BIT 1
`define CTRL_WRITE_SRC_LSB 4
`define CTRL_READ_SRC_LSB 8
`define CTRL_CONFIG_ACTIVE_BIT 16
`define CTRL_RESET 32'h00010000
`define STATUS_VALID_BIT 0
`define STATUS_CONFIG_BIT 1

`define CLOCK_SRC_FABRIC 4'h8
`define COUNT_BITS 16

`endif

//--- rtl/block_memory_pkg.sv
// types shared by the block memory files
package block_memory_pkg;
  typedef struct packed {
    logic [7:0] write_addr;
    logic [15:0] write_data;
    logic [15:0] write_mask;
    logic write_port_enable;
    logic write_clock_gate;
  } write_port_s;

  typedef struct packed {
    logic [7:0] read_addr;
    logic read_port_enable;
    logic read_clock_gate;
  } read_port_s;

  typedef struct packed {
    logic [7:0] global_clock_buffer;
    logic write_clock_fabric;
    logic read_clock_fabric;
    write_port_s wr;
    read_port_s rd;
  } pin_bundle_s;

  typedef enum logic [1:0] {
    bus_idle,
    bus_answer
  } bus_state_e;
endpackage

//--- rtl/pin_sync.sv
// two-flop synchroniser for a bundle of pins
module pin_sync #(
  parameter int WIDTH = 1
) (
  // clock and reset
  input wire logic clock,
  input wire logic srst,
  // pins and synchronised copy
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] stage1;
  logic [WIDTH-1:0] next_stage1;
  logic [WIDTH-1:0] next_sync_out;

  always_comb begin
    next_stage1 = async_in;
    next_sync_out = stage1;
    if (srst) begin
      next_stage1 = '0;
      next_sync_out = '0;
    end
  end

  always_ff @(posedge clock) begin
    stage1 <= next_stage1;
    sync_out <= next_sync_out;
  end
endmodule // pin_sync

//--- rtl/block_memory.sv
// two-port 256x16 block memory with selectable port clocks and avalon-mm configuration
`include "block_memory_regs.svh"

module block_memory (
  // system clock and reset
  input wire logic clock,
  input wire logic srst,
  // clock sources for the ports
  input wire logic [`GLOBAL_BUFFERS-1:0] global_clock_buffer,
  input wire logic write_clock_fabric,
  input wire logic read_clock_fabric,
  // write port
  input wire block_memory_pkg::write_port_s write_port,
  // read port
  input wire block_memory_pkg::read_port_s read_port,
  output logic [`MEM_DATA_BITS-1:0] read_data,
  output logic read_data_valid,
  // avalon-mm slave
  input wire logic [`BUS_ADDR_BITS-1:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  input wire logic [3:0] byteenable,
  output logic [31:0] readdata,
  output logic waitrequest
);
  import block_memory_pkg::*;

  localparam int DEPTH = `MEM_DEPTH;
  localparam int AW = `MEM_ADDR_BITS;
  localparam int DW = `MEM_DATA_BITS;
  localparam int CW = `COUNT_BITS;
  // reset word as a sized vector so its fields can be picked by part-select
  localparam logic [31:0] CTRL_INIT = `CTRL_RESET;

  // every pin is foreign to the system clock, including the port clocks
  pin_bundle_s pins_async;
  pin_bundle_s pins;

  assign pins_async = '{
    global_clock_buffer: global_clock_buffer,
    write_clock_fabric: write_clock_fabric,
    read_clock_fabric: read_clock_fabric,
    wr: write_port,
    rd: read_port
  };

  // controls travel with the clocks so each edge sees the values set up before it
  pin_sync #(
    .WIDTH($bits(pin_bundle_s))
  ) u_pin_sync (
    .clock(clock),
    .srst(srst),
    .async_in(pins_async),
    .sync_out(pins)
  );

  // configuration state
  logic write_falling;
  logic read_falling;
  logic [3:0] write_src;
  logic [3:0] read_src;
  logic config_active;
  logic [AW-1:0] preload_addr;
  logic [CW-1:0] write_count;
  logic [CW-1:0] read_count;
  logic next_write_falling;
  logic next_read_falling;
  logic [3:0] next_write_src;
  logic [3:0] next_read_src;
  logic next_config_active;
  logic [AW-1:0] next_preload_addr;
  logic [CW-1:0] next_write_count;
  logic [CW-1:0] next_read_count;

  // bus state
  bus_state_e bus_state;
  bus_state_e next_bus_state;
  logic [31:0] next_readdata;
  logic next_waitrequest;

  // port clock edge detection
  logic write_clock_level;
  logic read_clock_level;
  logic write_clock_prev;
  logic read_clock_prev;
  logic next_write_clock_prev;
  logic next_read_clock_prev;
  logic write_edge;
  logic read_edge;

  // memory
  logic [DW-1:0] mem [DEPTH];
  logic mem_we;
  logic [AW-1:0] mem_write_addr;
  logic [DW-1:0] mem_wword;
  logic user_write;
  logic user_read;
  logic preload_write;
  logic bus_take;
  logic [31:0] bus_wmask;
  logic [31:0] control_word;
  logic [DW-1:0] next_read_data;
  logic next_read_data_valid;

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] val,
                                        input logic [31:0] keep);
    merge = (old & ~keep) | (val & keep);
  endfunction

  always_comb begin
    control_word = 32'h00000000;
    control_word[`CTRL_WRITE_FALLING_BIT] = write_falling;
    control_word[`CTRL_READ_FALLING_BIT] = read_falling;
    control_word[`CTRL_WRITE_SRC_LSB +: 4] = write_src;
    control_word[`CTRL_READ_SRC_LSB +: 4] = read_src;
    control_word[`CTRL_CONFIG_ACTIVE_BIT] = config_active;
  end

  // clock source selection; source codes at or above fabric pick the fabric signal
  always_comb begin
    if (write_src >= `CLOCK_SRC_FABRIC) begin
      write_clock_level = pins.write_clock_fabric;
    end else begin
      write_clock_level = pins.global_clock_buffer[write_src[2:0]];
    end
    if (read_src >= `CLOCK_SRC_FABRIC) begin
      read_clock_level = pins.read_clock_fabric;
    end else begin
      read_clock_level = pins.global_clock_buffer[read_src[2:0]];
    end
  end

  // switching source or polarity while a clock runs can fake one edge
  always_comb begin
    next_write_clock_prev = write_clock_level;
    next_read_clock_prev = read_clock_level;
    if (srst) begin
      next_write_clock_prev = 1'b0;
      next_read_clock_prev = 1'b0;
    end
  end

  always_ff @(posedge clock) begin
    write_clock_prev <= next_write_clock_prev;
    read_clock_prev <= next_read_clock_prev;
  end

  always_comb begin
    if (write_falling) begin
      write_edge = write_clock_prev && !write_clock_level;
    end else begin
      write_edge = !write_clock_prev && write_clock_level;
    end
    if (read_falling) begin
      read_edge = read_clock_prev && !read_clock_level;
    end else begin
      read_edge = !read_clock_prev && read_clock_level;
    end
  end

  // port qualification, each port from its own pins; config mode also blocks the write port
  always_comb begin
    user_write = write_edge && pins.wr.write_port_enable && pins.wr.write_clock_gate
                 && !config_active && !srst;
    user_read = read_edge && pins.rd.read_port_enable && pins.rd.read_clock_gate
                && !srst;
  end

  // bus handshake: a request waits one cycle, then is taken at the edge with waitrequest low
  always_comb begin
    bus_take = (read || write) && !waitrequest;
    bus_wmask = {{8{byteenable[3]}}, {8{byteenable[2]}}, {8{byteenable[1]}}, {8{byteenable[0]}}};
    preload_write = bus_take && write && address == `PRELOAD_DATA_OFFSET && config_active;
  end

  always_comb begin
    next_bus_state = bus_state;
    next_waitrequest = 1'b1;
    next_readdata = readdata;
    unique case (bus_state)
      bus_idle: begin
        if (read || write) begin
          next_bus_state = bus_answer;
          next_waitrequest = 1'b0;
          // a write leaves the last read answer standing
          if (read) begin
            next_readdata = 32'h00000000;
            unique case (address)
              `CONTROL_OFFSET: next_readdata = control_word;
              `PRELOAD_ADDR_OFFSET: next_readdata = {24'h000000, preload_addr};
              `PRELOAD_DATA_OFFSET: next_readdata = {16'h0000, mem[preload_addr]};
              `STATUS_OFFSET: begin
                next_readdata[`STATUS_VALID_BIT] = read_data_valid;
                next_readdata[`STATUS_CONFIG_BIT] = config_active;
              end
              `WRITE_COUNT_OFFSET: next_readdata = {16'h0000, write_count};
              `READ_COUNT_OFFSET: next_readdata = {16'h0000, read_count};
              default: next_readdata = 32'h00000000;
            endcase
          end
        end
      end
      bus_answer: begin
        next_bus_state = bus_idle;
      end
    endcase
    if (srst) begin
      next_bus_state = bus_idle;
      next_waitrequest = 1'b1;
      next_readdata = 32'h00000000;
    end
  end

  always_ff @(posedge clock) begin
    bus_state <= next_bus_state;
    waitrequest <= next_waitrequest;
    readdata <= next_readdata;
  end

  // configuration registers
  always_comb begin
    logic [31:0] ctrl;
    ctrl = merge(control_word, writedata, bus_wmask);
    next_write_falling = write_falling;
    next_read_falling = read_falling;
    next_write_src = write_src;
    next_read_src = read_src;
    next_config_active = config_active;
    next_preload_addr = preload_addr;
    next_write_count = write_count;
    next_read_count = read_count;
    if (bus_take && write) begin
      if (address == `CONTROL_OFFSET) begin
        next_write_falling = ctrl[`CTRL_WRITE_FALLING_BIT];
        next_read_falling = ctrl[`CTRL_READ_FALLING_BIT];
        next_write_src = ctrl[`CTRL_WRITE_SRC_LSB +: 4];
        next_read_src = ctrl[`CTRL_READ_SRC_LSB +: 4];
        next_config_active = ctrl[`CTRL_CONFIG_ACTIVE_BIT];
      end
      if (address == `PRELOAD_ADDR_OFFSET && byteenable[0]) begin
        next_preload_addr = writedata[AW-1:0];
      end
    end
    // sequential preload: each data write in config mode steps the pointer
    if (preload_write) begin
      next_preload_addr = preload_addr + 8'h01;
    end
    if (user_write) begin
      next_write_count = write_count + 16'h0001;
    end
    if (user_read) begin
      next_read_count = read_count + 16'h0001;
    end
    if (srst) begin
      next_write_falling = CTRL_INIT[`CTRL_WRITE_FALLING_BIT];
      next_read_falling = CTRL_INIT[`CTRL_READ_FALLING_BIT];
      next_write_src = CTRL_INIT[`CTRL_WRITE_SRC_LSB +: 4];
      next_read_src = CTRL_INIT[`CTRL_READ_SRC_LSB +: 4];
      next_config_active = CTRL_INIT[`CTRL_CONFIG_ACTIVE_BIT];
      next_preload_addr = 8'h00;
      next_write_count = 16'h0000;
      next_read_count = 16'h0000;
    end
  end

  always_ff @(posedge clock) begin
    write_falling <= next_write_falling;
    read_falling <= next_read_falling;
    write_src <= next_write_src;
    read_src <= next_read_src;
    config_active <= next_config_active;
    preload_addr <= next_preload_addr;
    write_count <= next_write_count;
    read_count <= next_read_count;
  end

  // memory write: user port or preload, never both since config gates them apart
  always_comb begin
    mem_we = 1'b0;
    mem_write_addr = pins.wr.write_addr;
    mem_wword = mem[pins.wr.write_addr];
    if (user_write) begin
      mem_we = 1'b1;
      mem_wword = (mem[pins.wr.write_addr] & pins.wr.write_mask)
                  | (pins.wr.write_data & ~pins.wr.write_mask);
    end else if (preload_write) begin
      mem_we = 1'b1;
      mem_write_addr = preload_addr;
      mem_wword = writedata[DW-1:0];
    end
  end

  // no reset on the array: contents survive reset and reconfiguration
  always_ff @(posedge clock) begin
    if (mem_we) begin
      mem[mem_write_addr] <= mem_wword;
    end
  end

  // read path; array read sees the old word on a colliding edge
  always_comb begin
    next_read_data = read_data;
    next_read_data_valid = read_data_valid;
    if (user_read) begin
      next_read_data = mem[pins.rd.read_addr];
      next_read_data_valid = 1'b1;
    end
    if (srst) begin
      next_read_data_valid = 1'b0;
    end
  end

  // data register kept out of reset, only the valid flag tells when it is meaningful
  always_ff @(posedge clock) begin
    read_data <= next_read_data;
    read_data_valid <= next_read_data_valid;
  end
endmodule // block_memory

//--- verification/fabric_user.sv
// fabric logic model that drives the memory port pins
module fabric_user import block_memory_pkg::*; (
  // clock and reset
  input wire logic clock,
  input wire logic srst,
  // command from the bench
  input wire logic go,
  input wire logic level,
  input wire write_port_s want_wr,
  input wire read_port_s want_rd,
  output logic done,
  // pins toward the memory
  output logic port_clk,
  output write_port_s write_port,
  output read_port_s read_port
);
  int step;
  always @(posedge clock) begin
    done <= !srst && step == 12;
    if (srst) begin
      step <= 0;
      port_clk <= 1'b0;
      write_port <= '0;
      read_port <= '0;
    end else if (go && step == 0) begin
      step <= 1;
      write_port <= want_wr;
      read_port <= want_rd;
    end else if (step != 0) begin
      step <= (step == 12) ? 0 : step + 1;
      // controls settle well before and after the edge, as the pin sampling needs
      if (step == 3) port_clk <= level;
      if (step == 12) begin
        // released lines must not keep showing the last value
        write_port <= '{~write_port.write_addr, ~write_port.write_data, ~write_port.write_mask, 1'b0,
                        ~write_port.write_clock_gate};
        read_port <= '{~read_port.read_addr, 1'b0, ~read_port.read_clock_gate};
      end
    end
  end
endmodule // fabric_user

//--- verification/block_memory_chk.sv
// port assertions for the block memory
module block_memory_chk import block_memory_pkg::*; (
  // clock and reset
  input wire logic clock,
  input wire logic srst,
  // read port
  input wire read_port_s read_port,
  input wire logic [15:0] read_data,
  input wire logic read_data_valid,
  // avalon-mm slave
  input wire logic [4:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] readdata,
  input wire logic waitrequest
);
  default clocking @(posedge clock); endclocking
  default disable iff (srst);
  chk_answer_next: assert property ((read || write) && waitrequest |=> !waitrequest)
    else $error("bus answer late");
  chk_answer_once: assert property (!waitrequest |=> waitrequest)
    else $error("bus answer too long");
  chk_idle_wait: assert property (!(read || write) |=> waitrequest)
    else $error("bus answer without request");
  chk_rdata_stands: assert property (!(read && waitrequest) |=> $stable(readdata))
    else $error("readdata changed");
  chk_unmapped_zero: assert property (read && !waitrequest && address >= 5'h18 |-> readdata == 32'h0)
    else $error("unmapped read not zero");
  chk_status_ro: assert property (read && !waitrequest && address == 5'h0c |->
    readdata[31:2] == 30'h0 && (!readdata[0] || read_data_valid))
    else $error("status bits wrong");
  chk_valid_sticky: assert property (read_data_valid |=> read_data_valid)
    else $error("read valid dropped");
  chk_data_hold: assert property ((read_data_valid && !(read_port.read_port_enable &&
    read_port.read_clock_gate)) [*5] |=> $stable(read_data))
    else $error("read data moved without read");
endmodule // block_memory_chk
bind block_memory block_memory_chk chk (.clock(clock), .srst(srst), .read_port(read_port),
  .read_data(read_data), .read_data_valid(read_data_valid), .address(address), .read(read),
  .write(write), .readdata(readdata), .waitrequest(waitrequest));

//--- verification/block_memory_bench.sv
// self-checking bench for the two-port block memory
module block_memory_bench import block_memory_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  logic clock = 1'b0, srst = 1'b1, read = 1'b0, write = 1'b0, waitrequest, read_data_valid;
  logic [4:0] address = 5'h0;
  logic [31:0] writedata = 32'h0, readdata, q;
  logic [3:0] byteenable = 4'h0;
  logic [15:0] read_data;
  logic cmd_go = 1'b0, cmd_level = 1'b0, done, port_clk;
  write_port_s cmd_wr = '0, write_port;
  read_port_s cmd_rd = '0, read_port;
  int miscompares = 0, n_checks = 0, k;
  logic [7:0] addrs [4] = '{8'h00, 8'h01, 8'h80, 8'hff};
  always #5 clock = ~clock;
  fabric_user partner (.clock(clock), .srst(srst), .go(cmd_go), .level(cmd_level), .want_wr(cmd_wr),
    .want_rd(cmd_rd), .done(done), .port_clk(port_clk), .write_port(write_port), .read_port(read_port));
  block_memory dut (.clock(clock), .srst(srst), .global_clock_buffer({port_clk, 6'h00, port_clk}),
    .write_clock_fabric(port_clk), .read_clock_fabric(port_clk), .write_port(write_port), .read_port(read_port),
    .read_data(read_data), .read_data_valid(read_data_valid), .address(address), .read(read),
    .write(write), .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
    .waitrequest(waitrequest));
  task automatic test_done;
    $display("checks %0d miscompares %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
    int i;
    address <= a;
    writedata <= d;
    byteenable <= 4'hf;
    read <= !wr;
    write <= wr;
    for (i = 0; i < 20; i++) begin
      @(posedge clock);
      if (waitrequest === 1'b0) break;
    end
    q = readdata;
    read <= 1'b0;
    write <= 1'b0;
    @(posedge clock);
    if (i == 20) begin
      miscompares++;
      test_done();
    end
  endtask
  task automatic pulse(input logic lvl, input write_port_s w, input read_port_s r);
    int i;
    cmd_level <= lvl;
    cmd_wr <= w;
    cmd_rd <= r;
    cmd_go <= 1'b1;
    @(posedge clock);
    cmd_go <= 1'b0;
    for (i = 0; i < 40; i++) begin
      @(posedge clock);
      if (done === 1'b1) break;
    end
    @(posedge clock);
    if (i == 40) begin
      miscompares++;
      test_done();
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] d, input logic [15:0] m);
    pulse(1'b1, '{a, d, m, 1'b1, 1'b1}, '0);
    pulse(1'b0, '0, '0);
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [15:0] exp);
    pulse(1'b1, '0, '{a, 1'b1, 1'b1});
    pulse(1'b0, '0, '0);
    check("read_data", read_data, exp);
  endtask
  task automatic s_config;
    bus(1'b0, 5'h00, 0);
    check("control", q, 32'h00010000);
    check("valid", read_data_valid, 0);
    bus(1'b1, 5'h04, 32'h5);
    bus(1'b1, 5'h08, 32'h1234);
    bus(1'b0, 5'h04, 0);
    check("preload addr", q, 32'h6);
    wr(8'h05, 16'hffff, 16'h0000);
    bus(1'b1, 5'h00, 32'h0);
    rd_chk(8'h05, 16'h1234);
    bus(1'b0, 5'h0c, 0);
    check("status", q, 32'h1);
  endtask
  task automatic s_data;
    wr(8'h05, 16'habcd, 16'hff00);
    rd_chk(8'h05, 16'h12cd);
    for (k = 0; k < 4; k++) wr(addrs[k], {addrs[k], ~addrs[k]}, 16'h0);
    for (k = 0; k < 4; k++) rd_chk(addrs[k], {addrs[k], ~addrs[k]});
    // one of enable or gate low at a time
    for (k = 0; k < 2; k++) begin
      pulse(1'b1, '{8'h01, 16'h5555, 16'h0, k[0], !k[0]}, '{8'h00, k[0], !k[0]});
      pulse(1'b0, '0, '0);
      check("gated read", read_data, 16'hff00);
    end
    rd_chk(8'h01, 16'h01fe);
  endtask
  task automatic s_edges;
    pulse(1'b1, '{8'h80, 16'hbeef, 16'h0, 1'b1, 1'b1}, '{8'h80, 1'b1, 1'b1});
    pulse(1'b0, '0, '0);
    check("collision", read_data, 16'h807f);
    rd_chk(8'h80, 16'hbeef);
    bus(1'b1, 5'h00, 32'h773);
    bus(1'b0, 5'h00, 0);
    check("control", q, 32'h773);
    bus(1'b0, 5'h1c, 0);
    check("unmapped", q, 32'h0);
    pulse(1'b1, '{8'h02, 16'h1111, 16'h0, 1'b1, 1'b1}, '{8'h01, 1'b1, 1'b1});
    check("rise ignored", read_data, 16'hbeef);
    pulse(1'b0, '{8'h02, 16'h1111, 16'h0, 1'b1, 1'b1}, '{8'h01, 1'b1, 1'b1});
    check("fall read", read_data, 16'h01fe);
    bus(1'b1, 5'h00, 32'h0);
    rd_chk(8'h02, 16'h1111);
    // both ports on the fabric source
    bus(1'b1, 5'h00, 32'h880);
    wr(8'h03, 16'h3333, 16'h0000);
    rd_chk(8'h03, 16'h3333);
    bus(1'b0, 5'h10, 0);
    check("write count", q, 32'h8);
    bus(1'b0, 5'h14, 0);
    check("read count", q, 32'hc);
  endtask
  initial begin
    repeat (3) @(posedge clock);
    srst <= 1'b0;
    repeat (4) @(posedge clock);
    s_config();
    s_data();
    s_edges();
    test_done();
  end
endmodule // block_memory_bench
